// ---- logic/sldc_regs.vh ----
// register map, field positions and reset values of the serial LED driver control
// assumes inclusion by the single design file of the block
`ifndef SLDC_REGS_VH
`define SLDC_REGS_VH

`define SLDC_ADDR_W        8
`define SLDC_OFF_CTRL      8'h00
`define SLDC_OFF_ONOFF     8'h04
`define SLDC_OFF_GAIN      8'h08
`define SLDC_OFF_SHIFT     8'h0c
`define SLDC_OFF_FAULT     8'h10
`define SLDC_OFF_INT_STAT  8'h14
`define SLDC_OFF_INT_MASK  8'h18

`define SLDC_CTRL_W        2
`define SLDC_CTRL_FORCE_OFF 0
`define SLDC_CTRL_FAULT_TEST 1
`define SLDC_CTRL_RST      2'h0

`define SLDC_INT_W         5
`define SLDC_INT_LATCH     0
`define SLDC_INT_OPEN      1
`define SLDC_INT_SHORT     2
`define SLDC_INT_HOT       3
`define SLDC_INT_WORD      4
`define SLDC_INT_RST       5'h00

`define SLDC_FAULT_OPEN_LSB  0
`define SLDC_FAULT_SHORT_LSB 16

`define SLDC_CNT_W         4
`define SLDC_CNT_LAST      4'hf
`define SLDC_CNT_RST       4'h0

`endif

// ---- logic/sldc_top.v ----
// serial LED driver control: shift register, on/off and gain latches, cascade output,
// open-drain fault flag and an APB register file with interrupt
// assumes pins from the display controller are asynchronous to i_clk, which runs at 100 MHz
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "sldc_regs.vh"

module sldc_top #(
  parameter CH_N   = 16,
  parameter GAIN_W = 6
) (
  input  wire              i_clk,
  input  wire              i_arst_n,
  // controller pins
  input  wire              i_shift_clk,
  input  wire              i_serial_in,
  input  wire              i_strobe,
  input  wire              i_path_select,
  input  wire              i_enable_n,
  input  wire              i_cascade_trigger_select,
  output reg               o_serial_out,
  // channel drive and analog side
  output reg  [CH_N-1:0]   o_channel_sink,
  output reg  [GAIN_W-1:0] o_current_gain,
  input  wire [CH_N-1:0]   i_led_open,
  input  wire [CH_N-1:0]   i_led_short,
  input  wire              i_overheat,
  // open-drain fault flag: output level always low, enable high while pulling
  output wire              o_alarm_out,
  output reg               o_alarm_oe,
  // APB slave
  input  wire              i_psel,
  input  wire              i_penable,
  input  wire              i_pwrite,
  input  wire [31:0]       i_paddr,
  input  wire [31:0]       i_pwdata,
  output wire              o_pready,
  output reg  [31:0]       o_prdata,
  output reg               o_pslverr,
  output wire              o_irq
);

  localparam SYNC_W = 6 + 2 * CH_N + 1;

  // three-stage pin sampling; a change is taken once stages two and three agree
  reg  [SYNC_W-1:0] sync1;
  reg  [SYNC_W-1:0] sync2;
  reg  [SYNC_W-1:0] sync3;
  reg  [SYNC_W-1:0] filt;
  wire [SYNC_W-1:0] pins;
  wire [SYNC_W-1:0] next_filt;
  integer           k;

  // bit order here fixes the slices taken from filt below
  assign pins = {
    i_overheat,
    i_led_short,
    i_led_open,
    i_cascade_trigger_select,
    i_enable_n,
    i_path_select,
    i_strobe,
    i_serial_in,
    i_shift_clk
  };

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1 <= {SYNC_W{1'b0}};
      sync2 <= {SYNC_W{1'b0}};
      sync3 <= {SYNC_W{1'b0}};
    end else begin
      sync1 <= pins;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g = g + 1) begin : g_filt
      assign next_filt[g] = (sync2[g] == sync3[g]) ? sync3[g] : filt[g];
    end
  endgenerate

  // reset loads enable_n as 1; the zeroed sync stages clear it at the first clock after reset
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      filt <= {{(SYNC_W-5){1'b0}}, 1'b1, 4'h0};
    end else begin
      filt <= next_filt;
    end
  end

  wire              sclk      = filt[0];
  wire              sdata     = filt[1];
  wire              strobe    = filt[2];
  wire              path_sel  = filt[3];
  wire              enable_n  = filt[4];
  wire              trig_sel  = filt[5];
  wire [CH_N-1:0]   led_open  = filt[6 +: CH_N];
  wire [CH_N-1:0]   led_short = filt[6+CH_N +: CH_N];
  wire              overheat  = filt[6+2*CH_N];

  wire sclk_rise   = next_filt[0] & ~sclk;
  wire sclk_fall   = ~next_filt[0] & sclk;
  wire strobe_rise = next_filt[2] & ~strobe;

  // shift register and latches
  reg  [CH_N-1:0]       shift;
  reg  [CH_N-1:0]       onoff;
  reg  [GAIN_W-1:0]     gain;
  reg  [`SLDC_CNT_W-1:0] bit_cnt;
  reg                    word_done;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shift <= {CH_N{1'b0}};
    end else if (sclk_rise) begin
      shift <= {shift[CH_N-2:0], sdata};
    end
  end

  // counts shift edges since the last strobe; flags the sixteenth
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bit_cnt   <= `SLDC_CNT_RST;
      word_done <= 1'b0;
    end else begin
      word_done <= 1'b0;
      if (sclk_rise) begin
        bit_cnt <= bit_cnt + 1'b1;
        if (bit_cnt == `SLDC_CNT_LAST)
          word_done <= 1'b1;
      end else if (strobe_rise) begin
        bit_cnt <= `SLDC_CNT_RST;
      end
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      onoff <= {CH_N{1'b0}};
      gain  <= {GAIN_W{1'b1}};
    end else if (strobe) begin
      if (!path_sel)
        onoff <= shift;
      else
        gain  <= shift[GAIN_W-1:0];
    end
  end

  // cascade output: rising-edge update when low, falling-edge update when high
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_serial_out <= 1'b0;
    end else if (trig_sel ? sclk_fall : sclk_rise) begin
      o_serial_out <= trig_sel ? shift[CH_N-1] : shift[CH_N-2];
    end
  end

  // software control
  reg  [`SLDC_CTRL_W-1:0] ctrl;
  reg  [`SLDC_INT_W-1:0]  int_stat;
  reg  [`SLDC_INT_W-1:0]  int_mask;
  wire                    force_off  = ctrl[`SLDC_CTRL_FORCE_OFF];
  wire                    fault_test = ctrl[`SLDC_CTRL_FAULT_TEST];

  // open/short only meaningful on channels being driven
  wire [CH_N-1:0] drive   = o_channel_sink;
  wire            any_open  = |(led_open & drive);
  wire            any_short = |(led_short & drive);
  wire            fault     = any_open | any_short | overheat | fault_test;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_channel_sink <= {CH_N{1'b0}};
    end else begin
      o_channel_sink <= (enable_n | force_off) ? {CH_N{1'b0}} : onoff;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_current_gain <= {GAIN_W{1'b1}};
    end else begin
      o_current_gain <= gain;
    end
  end

  // alarm pulls one clock after the fault is seen
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_alarm_oe <= 1'b0;
    end else begin
      o_alarm_oe <= fault;
    end
  end

  assign o_alarm_out = 1'b0;

  // APB slave, zero wait states, read data captured in the setup cycle
  wire                    setup   = i_psel & ~i_penable;
  wire                    wr_acc  = i_psel & i_penable & i_pwrite;
  wire [`SLDC_ADDR_W-1:0] addr    = i_paddr[`SLDC_ADDR_W-1:0];

  // only the seven aligned word offsets answer without error
  function mapped;
    input [31:0] a;
    begin
      mapped = 1'b0;
      if (a[31:`SLDC_ADDR_W] == {(32-`SLDC_ADDR_W){1'b0}}) begin
        case (a[`SLDC_ADDR_W-1:0])
          `SLDC_OFF_CTRL:     mapped = 1'b1;
          `SLDC_OFF_ONOFF:    mapped = 1'b1;
          `SLDC_OFF_GAIN:     mapped = 1'b1;
          `SLDC_OFF_SHIFT:    mapped = 1'b1;
          `SLDC_OFF_FAULT:    mapped = 1'b1;
          `SLDC_OFF_INT_STAT: mapped = 1'b1;
          `SLDC_OFF_INT_MASK: mapped = 1'b1;
          default:            mapped = 1'b0;
        endcase
      end
    end
  endfunction

  wire hit = mapped(i_paddr);

  assign o_pready = 1'b1;

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0000_0000;
    case (addr)
      `SLDC_OFF_CTRL:     rd_mux[`SLDC_CTRL_W-1:0] = ctrl;
      `SLDC_OFF_ONOFF:    rd_mux[CH_N-1:0]         = onoff;
      `SLDC_OFF_GAIN:     rd_mux[GAIN_W-1:0]       = gain;
      `SLDC_OFF_SHIFT:    rd_mux[CH_N-1:0]         = shift;
      `SLDC_OFF_FAULT: begin
        rd_mux[`SLDC_FAULT_OPEN_LSB +: CH_N]  = led_open;
        rd_mux[`SLDC_FAULT_SHORT_LSB +: CH_N] = led_short;
      end
      `SLDC_OFF_INT_STAT: rd_mux[`SLDC_INT_W-1:0]  = int_stat;
      `SLDC_OFF_INT_MASK: rd_mux[`SLDC_INT_W-1:0]  = int_mask;
      default:            rd_mux = 32'h0000_0000;
    endcase
    if (!hit)
      rd_mux = 32'h0000_0000;
  end

  // read data is taken in the setup cycle and stands through the access phase
  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_prdata <= 32'h0000_0000;
    end else if (setup) begin
      o_prdata <= i_pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_pslverr <= ~hit;
    end
  end

  // interrupt events; a new event wins over a write-one clear in the same cycle
  wire [`SLDC_INT_W-1:0] events;
  reg                    open_d;
  reg                    short_d;
  reg                    hot_d;

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      open_d  <= 1'b0;
      short_d <= 1'b0;
      hot_d   <= 1'b0;
    end else begin
      open_d  <= any_open;
      short_d <= any_short;
      hot_d   <= overheat;
    end
  end

  assign events[`SLDC_INT_LATCH] = strobe_rise;
  assign events[`SLDC_INT_OPEN]  = any_open & ~open_d;
  assign events[`SLDC_INT_SHORT] = any_short & ~short_d;
  assign events[`SLDC_INT_HOT]   = overheat & ~hot_d;
  assign events[`SLDC_INT_WORD]  = word_done;

  // write access phase to a given mapped offset
  function reg_wr;
    input [`SLDC_ADDR_W-1:0] off;
    begin
      reg_wr = wr_acc && hit && (addr == off);
    end
  endfunction

  wire [`SLDC_INT_W-1:0] w1c =
    reg_wr(`SLDC_OFF_INT_STAT) ? i_pwdata[`SLDC_INT_W-1:0]
                               : {`SLDC_INT_W{1'b0}};

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_stat <= `SLDC_INT_RST;
    end else begin
      int_stat <= (int_stat & ~w1c) | events;
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl <= `SLDC_CTRL_RST;
    end else if (reg_wr(`SLDC_OFF_CTRL)) begin
      ctrl <= i_pwdata[`SLDC_CTRL_W-1:0];
    end
  end

  always @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_mask <= `SLDC_INT_RST;
    end else if (reg_wr(`SLDC_OFF_INT_MASK)) begin
      int_mask <= i_pwdata[`SLDC_INT_W-1:0];
    end
  end

  assign o_irq = |(int_stat & int_mask);

endmodule // sldc_top

// ---- bench/sldc_top_chk.sv ----
// checker: pin and bus relations of the serial LED driver control
// assumes binding to sldc_top, whose pins pass a three-flop filter
`timescale 1ns/100ps
module sldc_top_chk #(
  parameter CH_N   = 16,
  parameter GAIN_W = 6
) (
  input wire logic              i_clk,
  input wire logic              i_arst_n,
  input wire logic              i_strobe,
  input wire logic              i_path_select,
  input wire logic              i_enable_n,
  input wire logic              i_overheat,
  input wire logic              i_psel,
  input wire logic              i_penable,
  input wire logic [31:0]       i_paddr,
  input wire logic [CH_N-1:0]   o_channel_sink,
  input wire logic [GAIN_W-1:0] o_current_gain,
  input wire logic              o_alarm_out,
  input wire logic              o_alarm_oe,
  input wire logic              o_pslverr
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence quiet_s; (!i_strobe && !i_enable_n && !i_psel)[*7]; endsequence
  sequence gain_s; (i_strobe && i_path_select && !i_enable_n && !i_psel)[*7]; endsequence
  sequence sink_s; (i_strobe && !i_path_select && !i_psel)[*7]; endsequence
  sequence setup_s; i_psel && !i_penable; endsequence
  hold_sink_a: assert property (quiet_s |-> $stable(o_channel_sink))
    else $error("channels moved while strobe low");
  keep_sink_a: assert property (gain_s |-> $stable(o_channel_sink))
    else $error("channels moved on gain path");
  keep_gain_a: assert property (sink_s |-> $stable(o_current_gain))
    else $error("gain moved on on/off path");
  en_off_a: assert property (i_enable_n[*6] |-> o_channel_sink == '0)
    else $error("channels on while disabled");
  hot_alarm_a: assert property (i_overheat[*6] |-> o_alarm_oe)
    else $error("alarm not pulled on overheat");
  alarm_low_a: assert property (o_alarm_out == 1'b0)
    else $error("alarm level not low");
  unmap_err_a: assert property (setup_s and i_paddr[7:0] > 8'h18 |=> o_pslverr)
    else $error("no error on unmapped access");
  map_ok_a: assert property (setup_s and i_paddr <= 32'h18 && i_paddr[1:0] == 2'b00
                             |=> !o_pslverr)
    else $error("error on mapped access");
endmodule // sldc_top_chk

bind sldc_top sldc_top_chk #(.CH_N(CH_N), .GAIN_W(GAIN_W)) u_sldc_top_chk (.*);

// ---- bench/sldc_ctl_model.sv ----
// controller model: shifts words first bit to bit15 and pulses the strobe
// assumes send is entered just after a rising edge of i_clk
`timescale 1ns/100ps
module sldc_ctl_model (
  input  wire  i_clk,
  output logic o_shift_clk   = 1'b0,
  output logic o_serial_in   = 1'b0,
  output logic o_strobe      = 1'b0,
  output logic o_path_select = 1'b0
);
  // 80 ns bit period stays below the cascade limit in both modes
  task automatic send(input logic [15:0] w, input logic sel, input logic pulse);
    o_path_select <= sel;
    for (int b = 15; b >= 0; b--) begin
      o_serial_in <= w[b];
      repeat (4) @(posedge i_clk);
      o_shift_clk <= 1'b1;
      repeat (4) @(posedge i_clk);
      o_shift_clk <= 1'b0;
    end
    // hold time over: show the inverse, not the last bit
    o_serial_in <= ~w[0];
    repeat (4) @(posedge i_clk);
    o_strobe <= pulse;
    repeat (8) @(posedge i_clk);
    o_strobe <= 1'b0;
    repeat (8) @(posedge i_clk);
  endtask
endmodule // sldc_ctl_model

// ---- bench/testbench.sv ----
// testbench: APB master, fault pins and checks of the LED driver control
// assumes sldc_top, the controller model and one 100 MHz clock
`timescale 1ns/100ps
`include "sldc_regs.vh"
module testbench;
  logic        i_clk = 0, i_arst_n = 0, en_n = 0, tsel = 0, hot = 0, perr;
  logic        psel = 0, pen = 0, pwr = 0;
  logic [15:0] lopen = 0, lshort = 0;
  logic [31:0] paddr = 0, pwdata = 0, q;
  wire         sclk, sdi, stb, psl, sdo, alarm, alarm_oe, pready, err, irq;
  wire [15:0]  sink;
  wire [5:0]   gain;
  wire [31:0]  prdata;
  int          error_cnt = 0, tests_run = 0;
  initial forever #5 i_clk = ~i_clk;
  sldc_ctl_model u_sldc_ctl_model (.i_clk(i_clk), .o_shift_clk(sclk), .o_serial_in(sdi),
    .o_strobe(stb), .o_path_select(psl));
  sldc_top u_sldc_top (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_shift_clk(sclk),
    .i_serial_in(sdi), .i_strobe(stb), .i_path_select(psl), .i_enable_n(en_n),
    .i_cascade_trigger_select(tsel), .o_serial_out(sdo), .o_channel_sink(sink),
    .o_current_gain(gain), .i_led_open(lopen), .i_led_short(lshort), .i_overheat(hot),
    .o_alarm_out(alarm), .o_alarm_oe(alarm_oe), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_prdata(prdata), .o_pslverr(err), .o_irq(irq));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1; pen <= 0; pwr <= w; paddr <= {24'h0, a}; pwdata <= d;
    @(posedge i_clk);
    pen <= 1;
    n = 0;
    do begin @(posedge i_clk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin error_cnt++; wrap_up; end
    q = prdata; perr = err;
    psel <= 0; pen <= 0;
    @(posedge i_clk);
  endtask
  task automatic t_latch;
    apb(0, 8'h1c, 0); chk("unmapped err", perr, 1); chk("unmapped data", q, 0);
    u_sldc_ctl_model.send(16'ha5c3, 0, 1); chk("sink", sink, 16'ha5c3);
    u_sldc_ctl_model.send(16'h0ff0, 0, 0); chk("held", sink, 16'ha5c3);
    chk("sdo", sdo, 0);
    apb(0, `SLDC_OFF_SHIFT, 0); chk("shift", q, 32'h0ff0);
    u_sldc_ctl_model.send(16'hffc0, 1, 1); chk("gain", gain, 6'h00);
    chk("sink kept", sink, 16'ha5c3);
    tsel <= 1; u_sldc_ctl_model.send(16'h8001, 0, 0); chk("sdo m1", sdo, 1);
    tsel <= 0;
  endtask
  task automatic t_enable;
    en_n <= 1; wt(7); chk("off", sink, 0);
    en_n <= 0; wt(7); chk("on", sink, 16'ha5c3);
    apb(1, `SLDC_OFF_CTRL, 1); wt(2); chk("forced", sink, 0);
    apb(1, `SLDC_OFF_CTRL, 2); wt(2); chk("fault test", alarm_oe, 1);
    apb(1, `SLDC_OFF_CTRL, 0); wt(2); chk("test off", alarm_oe, 0);
  endtask
  task automatic t_fault;
    for (int k = 0; k < 3; k++) begin
      lopen <= (k == 0) ? 16'h1 : 16'h0; lshort <= (k == 1) ? 16'h2 : 16'h0; hot <= (k == 2);
      wt(8); chk("alarm", {alarm, alarm_oe}, 2'b01);
      apb(0, `SLDC_OFF_FAULT, 0);
      chk("fault reg", q, (k == 0) ? 32'h1 : (k == 1) ? 32'h0002_0000 : 32'h0);
      apb(0, `SLDC_OFF_INT_STAT, 0); chk("event", q[`SLDC_INT_OPEN + k], 1);
      lopen <= 0; lshort <= 0; hot <= 0; wt(8); chk("alarm off", alarm_oe, 0);
    end
    chk("latch event", q[`SLDC_INT_LATCH], 1); chk("word event", q[`SLDC_INT_WORD], 1);
    apb(1, `SLDC_OFF_INT_MASK, 0); chk("masked", irq, 0);
    apb(1, `SLDC_OFF_INT_MASK, 32'h1 << `SLDC_INT_HOT); chk("irq", irq, 1);
    apb(1, `SLDC_OFF_INT_STAT, 32'h1f); chk("cleared", irq, 0);
  endtask
  initial begin
    wt(5); i_arst_n <= 1; wt(1);
    t_latch; t_enable; t_fault;
    wrap_up;
  end
endmodule // testbench
